// File: hdl/trim_store.sv
// Nonvolatile trimming store with a registered read port.
`timescale 1ns/1ps
module trim_store #(
  parameter int WORDS = 8,
  parameter int AW = 3
) (
  input wire logic i_clk, // System clock.
  input wire logic [AW-1:0] i_addr, // Word to read.
  output logic [7:0] o_data // Word read, one cycle later.
);
  // Factory contents are fixed constants of this model; the values are arbitrary.
  function automatic logic [7:0] trim_word(input logic [AW-1:0] idx);
    trim_word = 8'h80 ^ 8'(idx);
  endfunction

  // Registered read.
  always_ff @(posedge i_clk) begin
    o_data <= trim_word(i_addr);
  end
endmodule

// File: hdl/uvi_ctrl.sv
// Control, status and interrupt register set of the UV index sensor.
`timescale 1ns/1ps
`include "uvi_ctrl_cfg.svh"

// Functional notes
// - Hold output while previous result is unread.
// - Rate select samples continuously at 1 Hz.
// - Both mode bits zero means power down.
// - Reload copies trimming words, then self-clears.
// - Reload acts after one sampling period.
// - Two-wire disable bit turns I2C off.
// - Three-wire select picks SPI pin arrangement.
// - One-shot measures once, then self-clears.
// - Polarity bit sets interrupt pin level.
// - Drive bit picks push-pull or open drain.
// - Source select routes event to pin.
// - Circuit enable gates threshold events.
// - Latch bit makes event flags sticky.
// - Low event when value below threshold.
// - High event when value above threshold.
// - Flags register reports active, low, high.
// - Eight-bit threshold for event comparison.
// - Ready flag sets on sample, clears on read.
// - Result register holds latest index byte.
// - Data ready can drive interrupt pin.
module uvi_ctrl #(
  parameter int RATE_CYCLES = `RATE_CYCLES,
  parameter int TRIM_WORDS = `TRIM_WORDS
) (
  input wire logic i_clk, // 200 MHz clock.
  input wire logic i_rstn, // Synchronous reset, active low.
  input wire uvi_ctrl_pkg::reg_addr_t i_reg_addr, // Register address.
  input wire logic i_reg_wr, // Write strobe.
  input wire logic i_reg_rd, // Read strobe.
  input wire uvi_ctrl_pkg::byte_t i_reg_wdata, // Write data.
  output uvi_ctrl_pkg::byte_t o_reg_rdata, // Read data, one cycle after strobe.
  output logic o_acq_start, // Pulse starting one acquisition.
  input wire logic i_acq_done, // Acquisition finished.
  input wire uvi_ctrl_pkg::byte_t i_acq_value, // Measured index.
  output logic o_power_down, // Sensor in power down.
  output logic o_i2c_enable, // Two-wire interface enabled.
  output logic o_spi_three_wire, // SPI shares one data pin.
  output logic o_cal_we, // Calibration register write.
  output logic [$clog2(TRIM_WORDS)-1:0] o_cal_addr, // Calibration register index.
  output uvi_ctrl_pkg::byte_t o_cal_data, // Calibration value.
  output logic o_int_out, // Interrupt pin output level.
  output logic o_int_oe // Interrupt pin output enable.
);
  import uvi_ctrl_pkg::*;

  localparam int AW = $clog2(TRIM_WORDS);
  localparam logic [31:0] RATE_LAST = 32'(RATE_CYCLES - 1);
  localparam logic [AW-1:0] TRIM_LAST = AW'(TRIM_WORDS - 1);

  // ----------------------------------------------------------------
  // Registers and decode
  // ----------------------------------------------------------------
  byte_t meas_ctrl_q, boot_ctrl_q, pin_ctrl_q, irq_cfg_q, thresh_q, result_q, pend_val_q;
  logic ready_q, pend_q, hi_flag_q, lo_flag_q;
  seq_state_e state_q;
  logic [31:0] rate_cnt_q, wait_cnt_q;
  logic [AW-1:0] rd_idx_q;
  logic [AW-1:0] data_idx_q; // Index of the word now on the store's read port.
  logic rd_pend_q;
  byte_t trim_data;

  function automatic logic hit(input reg_addr_t a, input reg_addr_t r);
    hit = (a == r);
  endfunction

  logic wr_boot, rd_result, rd_flags, rate_tick, acq_end, copy_last, load_now, int_src;
  byte_t load_val;
  assign wr_boot = i_reg_wr && hit(i_reg_addr, `ADDR_BOOT_CTRL);
  assign rd_result = i_reg_rd && hit(i_reg_addr, `ADDR_RESULT);
  assign rd_flags = i_reg_rd && hit(i_reg_addr, `ADDR_IRQ_FLAGS);
  assign rate_tick = meas_ctrl_q[`BIT_RATE_SEL] && (rate_cnt_q == RATE_LAST);
  assign acq_end = (state_q == ST_MEAS) && i_acq_done;
  assign copy_last = (state_q == ST_BOOT_COPY) && rd_pend_q && (data_idx_q == TRIM_LAST);

  // Writable registers; reserved bits are masked so they always read zero.
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      meas_ctrl_q <= `RST_BYTE;
      pin_ctrl_q <= `RST_BYTE;
      irq_cfg_q <= `RST_BYTE;
      thresh_q <= `RST_BYTE;
    end else if (i_reg_wr) begin
      if (hit(i_reg_addr, `ADDR_MEAS_CTRL)) meas_ctrl_q <= i_reg_wdata & `MASK_MEAS_CTRL;
      if (hit(i_reg_addr, `ADDR_PIN_CTRL)) pin_ctrl_q <= i_reg_wdata & `MASK_PIN_CTRL;
      if (hit(i_reg_addr, `ADDR_IRQ_CFG)) irq_cfg_q <= i_reg_wdata & `MASK_IRQ_CFG;
      if (hit(i_reg_addr, `ADDR_THRESH)) thresh_q <= i_reg_wdata;
    end
  end

  // Reload and one-shot bits self-clear; a host write in the same cycle wins.
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      boot_ctrl_q <= `RST_BYTE;
    end else if (wr_boot) begin
      boot_ctrl_q <= i_reg_wdata & `MASK_BOOT_CTRL;
    end else begin
      if (copy_last) boot_ctrl_q[`BIT_RELOAD] <= 1'b0;
      if (acq_end) boot_ctrl_q[`BIT_ONE_SHOT] <= 1'b0;
    end
  end

  // Registered read port; unmapped addresses read zero.
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_reg_rdata <= `RST_BYTE;
    end else if (i_reg_rd) begin
      unique case (i_reg_addr)
        `ADDR_MEAS_CTRL: o_reg_rdata <= meas_ctrl_q;
        `ADDR_BOOT_CTRL: o_reg_rdata <= boot_ctrl_q;
        `ADDR_PIN_CTRL: o_reg_rdata <= pin_ctrl_q;
        `ADDR_IRQ_CFG: o_reg_rdata <= irq_cfg_q;
        `ADDR_IRQ_FLAGS: o_reg_rdata <= {5'h00, hi_flag_q | lo_flag_q, lo_flag_q, hi_flag_q};
        `ADDR_THRESH: o_reg_rdata <= thresh_q;
        `ADDR_STATUS: o_reg_rdata <= {7'h00, ready_q};
        `ADDR_RESULT: o_reg_rdata <= result_q;
        default: o_reg_rdata <= `RST_BYTE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Sampling-rate divider, running only while rate select is set; the reload delay counts on its own wait counter.
  always_ff @(posedge i_clk) begin
    if (!i_rstn || !meas_ctrl_q[`BIT_RATE_SEL] || rate_tick) rate_cnt_q <= 32'h0;
    else rate_cnt_q <= rate_cnt_q + 32'h1;
  end

  // Mode sequencer: reload first, then periodic or single conversions.
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      state_q <= ST_IDLE;
      o_acq_start <= 1'b0;
      wait_cnt_q <= 32'h0;
    end else begin
      o_acq_start <= 1'b0;
      unique case (state_q)
        ST_IDLE: begin
          wait_cnt_q <= 32'h0;
          if (boot_ctrl_q[`BIT_RELOAD]) begin
            state_q <= ST_BOOT_WAIT;
          end else if (meas_ctrl_q[`BIT_RATE_SEL]) begin
            if (rate_tick) begin
              state_q <= ST_MEAS;
              o_acq_start <= 1'b1;
            end
          end else if (boot_ctrl_q[`BIT_ONE_SHOT]) begin
            state_q <= ST_MEAS;
            o_acq_start <= 1'b1;
          end
        end
        ST_MEAS: if (i_acq_done) state_q <= ST_IDLE;
        ST_BOOT_WAIT: begin
          wait_cnt_q <= wait_cnt_q + 32'h1;
          if (wait_cnt_q == RATE_LAST) state_q <= ST_BOOT_COPY;
        end
        ST_BOOT_COPY: if (copy_last) state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) o_power_down <= 1'b1;
    else o_power_down <= !meas_ctrl_q[`BIT_RATE_SEL] && !boot_ctrl_q[`BIT_ONE_SHOT];
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_i2c_enable <= 1'b1;
      o_spi_three_wire <= 1'b0;
    end else begin
      o_i2c_enable <= !boot_ctrl_q[`BIT_TWO_WIRE_OFF];
      o_spi_three_wire <= boot_ctrl_q[`BIT_THREE_WIRE];
    end
  end

  // ----------------------------------------------------------------
  // Trimming reload
  // ----------------------------------------------------------------
  trim_store #(.WORDS(TRIM_WORDS), .AW(AW)) u_trim (
    .i_clk(i_clk),
    .i_addr(rd_idx_q),
    .o_data(trim_data)
  );

  always_ff @(posedge i_clk) begin
    if (!i_rstn || state_q != ST_BOOT_COPY) begin
      rd_idx_q <= '0;
      data_idx_q <= '0;
      rd_pend_q <= 1'b0;
      o_cal_we <= 1'b0;
      o_cal_addr <= '0;
      o_cal_data <= `RST_BYTE;
    end else begin
      // The store answers one cycle late, so the index is delayed to stay paired with its word.
      rd_pend_q <= 1'b1;
      data_idx_q <= rd_idx_q;
      o_cal_we <= rd_pend_q;
      o_cal_addr <= data_idx_q;
      o_cal_data <= trim_data;
      if (rd_idx_q != TRIM_LAST) rd_idx_q <= rd_idx_q + AW'(1);
    end
  end

  // ----------------------------------------------------------------
  // Result, ready flag and threshold events
  // ----------------------------------------------------------------
  // hold new result while unread.
  assign load_now = (acq_end && !(meas_ctrl_q[`BIT_HOLD] && ready_q)) || (pend_q && !ready_q);
  assign load_val = (pend_q && !ready_q) ? pend_val_q : i_acq_value;

  // Result register with one pending slot for block update.
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      result_q <= `RST_BYTE;
      pend_val_q <= `RST_BYTE;
      pend_q <= 1'b0;
    end else begin
      if (load_now) result_q <= load_val;
      if (acq_end && meas_ctrl_q[`BIT_HOLD] && ready_q) begin
        pend_q <= 1'b1;
        pend_val_q <= i_acq_value;
      end else if (pend_q && !ready_q) begin
        pend_q <= 1'b0;
      end
    end
  end

  // ready set wins over read clear.
  always_ff @(posedge i_clk) begin
    if (!i_rstn) ready_q <= 1'b0;
    else if (load_now) ready_q <= 1'b1;
    else if (rd_result) ready_q <= 1'b0;
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      hi_flag_q <= 1'b0;
      lo_flag_q <= 1'b0;
    end else if (acq_end && irq_cfg_q[`BIT_CIRCUIT]) begin
      if (irq_cfg_q[`BIT_LATCH]) begin
        hi_flag_q <= (hi_flag_q & ~rd_flags) | (irq_cfg_q[`BIT_HI_EN] && i_acq_value > thresh_q);
        lo_flag_q <= (lo_flag_q & ~rd_flags) | (irq_cfg_q[`BIT_LO_EN] && i_acq_value < thresh_q);
      end else begin
        hi_flag_q <= irq_cfg_q[`BIT_HI_EN] && i_acq_value > thresh_q;
        lo_flag_q <= irq_cfg_q[`BIT_LO_EN] && i_acq_value < thresh_q;
      end
    end else if (rd_flags && irq_cfg_q[`BIT_LATCH]) begin
      hi_flag_q <= 1'b0;
      lo_flag_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt pin
  // ----------------------------------------------------------------
  // source routing.
  always_comb begin
    unique case (irq_src_e'(pin_ctrl_q[`BIT_SRC_HI:`BIT_SRC_LO]))
      SRC_READY: int_src = ready_q;
      SRC_HIGH: int_src = hi_flag_q;
      SRC_LOW: int_src = lo_flag_q;
      SRC_EITHER: int_src = hi_flag_q | lo_flag_q;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_int_out <= 1'b0;
      o_int_oe <= 1'b1;
    end else if (pin_ctrl_q[`BIT_DRIVE]) begin
      o_int_out <= 1'b0;
      o_int_oe <= !(int_src ^ pin_ctrl_q[`BIT_POL]);
    end else begin
      o_int_out <= int_src ^ pin_ctrl_q[`BIT_POL];
      o_int_oe <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  property p_push_pull;
    !pin_ctrl_q[`BIT_DRIVE] |=> o_int_oe && (o_int_out == ($past(int_src) ^ $past(pin_ctrl_q[`BIT_POL])));
  endproperty
  a_push_pull: assert property (p_push_pull) else $error("Push-pull pin level wrong.");
  property p_open_drain;
    pin_ctrl_q[`BIT_DRIVE] |=> !o_int_out && (o_int_oe == !($past(int_src) ^ $past(pin_ctrl_q[`BIT_POL])));
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("Open-drain pin wrong.");
  property p_ready_set;
    load_now |=> ready_q && (result_q == $past(load_val));
  endproperty
  a_ready_set: assert property (p_ready_set) else $error("Ready or result not loaded.");
  property p_ready_clear;
    rd_result && !load_now |=> !ready_q;
  endproperty
  a_ready_clear: assert property (p_ready_clear) else $error("Ready not cleared by read.");
  property p_power_down;
    state_q == ST_IDLE && !meas_ctrl_q[`BIT_RATE_SEL] && !boot_ctrl_q[`BIT_ONE_SHOT] |=> !o_acq_start;
  endproperty
  a_power_down: assert property (p_power_down) else $error("Acquisition in power down.");
  property p_periodic;
    state_q == ST_IDLE && rate_tick && !boot_ctrl_q[`BIT_RELOAD] |=> o_acq_start ##1 !o_acq_start;
  endproperty
  a_periodic: assert property (p_periodic) else $error("Periodic start missing.");
  property p_boot_wait;
    $rose(state_q == ST_BOOT_COPY) |-> $past(wait_cnt_q) == RATE_LAST;
  endproperty
  a_boot_wait: assert property (p_boot_wait) else $error("Reload started early.");
  property p_boot_clear;
    copy_last && !wr_boot |=> !boot_ctrl_q[`BIT_RELOAD] && o_cal_we;
  endproperty
  a_boot_clear: assert property (p_boot_clear) else $error("Reload bit not cleared.");
  property p_hold;
    acq_end && meas_ctrl_q[`BIT_HOLD] && ready_q |=> $stable(result_q) && pend_q;
  endproperty
  a_hold: assert property (p_hold) else $error("Result overwritten while held.");
  property p_no_event;
    !irq_cfg_q[`BIT_CIRCUIT] && !hi_flag_q && !lo_flag_q |=> !hi_flag_q && !lo_flag_q;
  endproperty
  a_no_event: assert property (p_no_event) else $error("Event with circuit off.");
  property p_latched;
    irq_cfg_q[`BIT_LATCH] && hi_flag_q && !rd_flags |=> hi_flag_q;
  endproperty
  a_latched: assert property (p_latched) else $error("Latched flag lost.");

  c_periodic: cover property (rate_tick ##[1:4] acq_end);
  c_one_shot: cover property (boot_ctrl_q[`BIT_ONE_SHOT] ##[1:20] !boot_ctrl_q[`BIT_ONE_SHOT]);
  c_reload: cover property (copy_last);
  c_latched: cover property (irq_cfg_q[`BIT_LATCH] && hi_flag_q ##1 rd_flags);
endmodule

// File: hdl/uvi_ctrl_cfg.svh
// Address map, field positions, reset values and timing counts of the UV index control block.
`ifndef UVI_CTRL_CFG_SVH
`define UVI_CTRL_CFG_SVH
`define ADDR_MEAS_CTRL 7'h20
`define ADDR_BOOT_CTRL 7'h21
`define ADDR_PIN_CTRL 7'h22
`define ADDR_IRQ_CFG 7'h23
`define ADDR_IRQ_FLAGS 7'h24
`define ADDR_THRESH 7'h25
`define ADDR_STATUS 7'h27
`define ADDR_RESULT 7'h28
`define MASK_MEAS_CTRL 8'h03
`define MASK_BOOT_CTRL 8'h99
`define MASK_PIN_CTRL 8'hc3
`define MASK_IRQ_CFG 8'h0f
`define RST_BYTE 8'h00
`define BIT_RATE_SEL 0
`define BIT_HOLD 1
`define BIT_ONE_SHOT 0
`define BIT_THREE_WIRE 3
`define BIT_TWO_WIRE_OFF 4
`define BIT_RELOAD 7
`define BIT_SRC_LO 0
`define BIT_SRC_HI 1
`define BIT_DRIVE 6
`define BIT_POL 7
`define BIT_HI_EN 0
`define BIT_LO_EN 1
`define BIT_LATCH 2
`define BIT_CIRCUIT 3
`define BIT_IRQ_ACTIVE 2
`define CLK_PERIOD_NS 5
`define RATE_PERIOD_NS 1000000000
`define RATE_CYCLES (`RATE_PERIOD_NS / `CLK_PERIOD_NS)
`define TRIM_WORDS 8
`endif

// File: hdl/uvi_ctrl_pkg.sv
// Types shared by the UV index control block.
package uvi_ctrl_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [6:0] reg_addr_t;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_MEAS = 4'b0010,
    ST_BOOT_WAIT = 4'b0100,
    ST_BOOT_COPY = 4'b1000
  } seq_state_e;
  typedef enum logic [1:0] {
    SRC_READY = 2'b00,
    SRC_HIGH = 2'b01,
    SRC_LOW = 2'b10,
    SRC_EITHER = 2'b11
  } irq_src_e;
endpackage

// File: sim/acq_front_model.sv
// Behavioural model of the sensing front end that answers acquisition requests.
`timescale 1ns/1ps
module acq_front_model (
  input wire logic i_clk, // System clock.
  input wire logic i_rstn, // Synchronous reset, active low.
  input wire logic i_start, // Acquisition request pulse.
  input wire uvi_ctrl_pkg::byte_t i_next, // Value returned by the next acquisition.
  output logic o_done, // Acquisition finished pulse.
  output uvi_ctrl_pkg::byte_t o_value // Measured index, valid with o_done only.
);
  import uvi_ctrl_pkg::*;
  int wait_q;
  logic slow_q;
  byte_t last_q;
  // Answers promptly and slowly in turn; outside o_done the value bus shows the inverse of the last value.
  always_ff @(posedge i_clk) begin
    o_done <= 1'b0;
    o_value <= ~last_q;
    if (!i_rstn) begin
      wait_q <= 0;
      slow_q <= 1'b0;
      last_q <= 8'h00;
    end else if (i_start) begin
      wait_q <= slow_q ? 7 : 2;
    end else if (wait_q == 1) begin
      o_done <= 1'b1;
      o_value <= i_next;
      last_q <= i_next;
      slow_q <= !slow_q;
      wait_q <= 0;
    end else if (wait_q > 1) begin
      wait_q <= wait_q - 1;
    end
  end
endmodule

// File: sim/tb_uvi_ctrl.sv
// Self-checking testbench of the UV index control block.
`timescale 1ns/1ps
module tb_uvi_ctrl;
  import uvi_ctrl_pkg::*;
  logic i_clk = 1'b0;
  logic i_rstn = 1'b0;
  reg_addr_t addr = 7'h00;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  byte_t wdata = 8'h00;
  byte_t rdata;
  byte_t nxt = 8'h00;
  byte_t acq_value;
  byte_t cal_data;
  logic [2:0] cal_addr;
  logic acq_start, acq_done, power_down, i2c_en, three_wire, cal_we, int_out, int_oe;
  int errors = 0;
  int comparisons = 0;
  int cycles = 0;
  int n;
  reg_addr_t dut_regs [8] = '{7'h20, 7'h21, 7'h22, 7'h23, 7'h24, 7'h25, 7'h27, 7'h28};

  // ----------------------------------------
  // Clock, design and front end
  // ----------------------------------------
  always #2.5 i_clk = ~i_clk;
  uvi_ctrl #(.RATE_CYCLES(16), .TRIM_WORDS(8)) dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_reg_addr(addr),
    .i_reg_wr(wr_s), .i_reg_rd(rd_s), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_acq_start(acq_start),
    .i_acq_done(acq_done), .i_acq_value(acq_value), .o_power_down(power_down), .o_i2c_enable(i2c_en),
    .o_spi_three_wire(three_wire), .o_cal_we(cal_we), .o_cal_addr(cal_addr), .o_cal_data(cal_data),
    .o_int_out(int_out), .o_int_oe(int_oe));
  acq_front_model fm (.i_clk(i_clk), .i_rstn(i_rstn), .i_start(acq_start), .i_next(nxt),
    .o_done(acq_done), .o_value(acq_value));

  // ----------------------------------------
  // Register access and checking tasks
  // ----------------------------------------
  task wr(input reg_addr_t a, input byte_t d);
    @(posedge i_clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge i_clk);
    wr_s <= 1'b0;
  endtask
  task chk(input byte_t got, input byte_t exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task rchk(input reg_addr_t a, input byte_t exp);
    @(posedge i_clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge i_clk);
    rd_s <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask
  // Checks interrupt pin enable and level once the pin register has caught up.
  task pchk(input byte_t cfg, input logic eoe, input logic eout);
    wr(7'h22, cfg);
    repeat (2) @(posedge i_clk);
    #1;
    chk(byte_t'({int_oe, int_out}), byte_t'({eoe, eout}));
  endtask
  task wait_done;
    int k;
    k = 0;
    do begin
      @(posedge i_clk);
      #1;
      k++;
    end while (acq_done !== 1'b1 && k < 200);
    // A front end that never answers counts as a mismatch.
    if (acq_done !== 1'b1) errors++;
    repeat (2) @(posedge i_clk);
  endtask
  task shot(input byte_t v);
    nxt <= v;
    wr(7'h21, 8'h01);
    wait_done();
    rchk(7'h28, v);
  endtask
  task gap(output int m);
    int k;
    k = 0;
    while (acq_start !== 1'b1 && k < 100) begin
      @(posedge i_clk);
      #1;
      k++;
    end
    m = 0;
    do begin
      @(posedge i_clk);
      #1;
      m++;
    end while (acq_start !== 1'b1 && m < 100);
  endtask
  task wrap_up;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Cuts a hung run short.
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      wrap_up();
    end
  end

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge i_clk);
    i_rstn <= 1'b1;
    foreach (dut_regs[i]) rchk(dut_regs[i], 8'h00); // register reset values
    chk(byte_t'({power_down, i2c_en, three_wire, int_oe, int_out}), 8'h1a);
    $display("test reset done");
    wr(7'h20, 8'hfe);
    rchk(7'h20, 8'h02);
    wr(7'h20, 8'h00);
    wr(7'h22, 8'hff);
    rchk(7'h22, 8'hc3);
    wr(7'h23, 8'hff);
    rchk(7'h23, 8'h0f);
    wr(7'h23, 8'h00);
    // Read-only place written and an unmapped place read, never written.
    wr(7'h24, 8'hff);
    rchk(7'h24, 8'h00);
    rchk(7'h26, 8'h00);
    wr(7'h21, 8'h18);
    rchk(7'h21, 8'h18);
    chk(byte_t'({i2c_en, three_wire}), 8'h01);
    wr(7'h21, 8'h00);
    $display("test masks done");
    wr(7'h25, 8'h05);
    rchk(7'h25, 8'h05);
    wr(7'h23, 8'h0b);
    nxt <= 8'h09;
    wr(7'h21, 8'h01);
    wait_done();
    rchk(7'h21, 8'h00);
    rchk(7'h27, 8'h01);
    rchk(7'h24, 8'h05);
    pchk(8'h00, 1'b1, 1'b1);
    pchk(8'h01, 1'b1, 1'b1);
    pchk(8'h02, 1'b1, 1'b0);
    pchk(8'h03, 1'b1, 1'b1);
    pchk(8'h81, 1'b1, 1'b0);
    pchk(8'hc1, 1'b1, 1'b0);
    pchk(8'h41, 1'b0, 1'b0);
    rchk(7'h28, 8'h09);
    rchk(7'h27, 8'h00);
    pchk(8'h00, 1'b1, 1'b0);
    shot(8'h02);
    rchk(7'h24, 8'h06);
    shot(8'h05);
    rchk(7'h24, 8'h00);
    wr(7'h23, 8'h03);
    shot(8'h09);
    rchk(7'h24, 8'h00);
    wr(7'h23, 8'h0f);
    shot(8'h09);
    shot(8'h05);
    rchk(7'h24, 8'h05);
    rchk(7'h24, 8'h00);
    wr(7'h23, 8'h0b);
    shot(8'h09);
    shot(8'h05);
    rchk(7'h24, 8'h00);
    $display("test one-shot and events done");
    wr(7'h20, 8'h01);
    gap(n);
    chk(byte_t'(n), 8'h10);
    nxt <= 8'h0c;
    wr(7'h20, 8'h03);
    wait_done();
    rchk(7'h28, 8'h05);
    rchk(7'h28, 8'h0c);
    nxt <= 8'h11;
    wait_done();
    nxt <= 8'h22;
    wait_done();
    rchk(7'h28, 8'h11);
    rchk(7'h28, 8'h22);
    wr(7'h20, 8'h01);
    nxt <= 8'h33;
    wait_done();
    nxt <= 8'h44;
    wait_done();
    rchk(7'h28, 8'h44);
    wr(7'h20, 8'h00);
    repeat (2) @(posedge i_clk);
    #1;
    n = 0;
    repeat (40) begin
      @(posedge i_clk);
      #1;
      if (acq_start === 1'b1) n++;
    end
    chk(byte_t'({power_down, n[6:0]}), 8'h80);
    $display("test periodic done");
    wr(7'h21, 8'h80);
    n = 0;
    do begin
      @(posedge i_clk);
      #1;
      n++;
    end while (cal_we !== 1'b1 && n < 100);
    chk(byte_t'(n >= 16 && n <= 22), 8'h01);
    for (int i = 0; i < 8; i++) begin
      chk(byte_t'({cal_we, 4'h0, cal_addr}), byte_t'(8'h80 | i));
      chk(cal_data, byte_t'(8'h80 ^ i));
      @(posedge i_clk);
      #1;
    end
    rchk(7'h21, 8'h00);
    $display("test reload done");
    wrap_up();
  end
endmodule
